// File: common/brs_defs.svh
`ifndef BRS_DEFS_SVH
`define BRS_DEFS_SVH

// Register indexes; byte address is four times the index
`define BRS_IDX_CTRL        8'h41
`define BRS_IDX_STATUS      8'h43
`define BRS_IDX_IRQ_STAT    8'h48
`define BRS_IDX_IRQ_MASK    8'h49

// Receive status register field positions
`define BRS_ST_SYNC         0
`define BRS_ST_ERR_OVF      1
`define BRS_ST_BIT_OVF      2
`define BRS_ST_BIT_ERR      3
`define BRS_ST_LOSS         4
`define BRS_ST_ZEROS        5
`define BRS_ST_ONES         6

// Control register field positions
`define BRS_CT_OVF_IE       5
`define BRS_CT_LOCK_IE      7

// Interrupt status and mask field positions
`define BRS_IQ_LOCK         0
`define BRS_IQ_BIT_OVF      1
`define BRS_IQ_ERR_OVF      2

// Reset values
`define BRS_CTRL_RST        8'h00
`define BRS_IRQ_MASK_RST    3'h0

// Bit counts of the checker
`define BRS_LOCK_RUN        32
`define BRS_UNLOCK_ERRS     6
`define BRS_UNLOCK_WIN      64
`define BRS_SAME_RUN        32

`endif

// File: common/brs_pkg.sv
package brs_pkg;
    // Pattern checker states
    typedef enum logic {
        BRS_HUNT,
        BRS_LOCKED
    } brs_lock_e;

    // AXI response code
    typedef logic [1:0] brs_resp_t;
endpackage

// File: verilog/brs_lock_tracker.sv
`include "brs_defs.svh"

module brs_lock_tracker
    import brs_pkg::*;
#(
    parameter int LOCK_RUN    = `BRS_LOCK_RUN,
    parameter int UNLOCK_ERRS = `BRS_UNLOCK_ERRS,
    parameter int UNLOCK_WIN  = `BRS_UNLOCK_WIN
) (
    input  wire logic clock_in,
    input  wire logic rst_b_in,
    input  wire logic bit_valid_in,
    input  wire logic bit_mismatch_in,
    input  wire logic resync_in,
    output logic      locked_out,
    output logic      hunt_start_out
);
    brs_lock_e   state_r;
    logic [6:0]  run_r;
    logic [6:0]  win_r;
    logic [3:0]  errs_r;
    logic        bad_bit;
    logic        too_many;

    assign bad_bit  = bit_valid_in && bit_mismatch_in;
    assign too_many = bad_bit && (errs_r == 4'(UNLOCK_ERRS - 1));

    // Hunt for a clean run, drop lock on an error burst within a window
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            state_r        <= BRS_HUNT;
            run_r          <= 7'h00;
            win_r          <= 7'h00;
            errs_r         <= 4'h0;
            hunt_start_out <= 1'b0;
        end else begin
            hunt_start_out <= 1'b0;
            unique case (state_r)
                BRS_HUNT: begin
                    if (bad_bit || resync_in) begin
                        run_r <= 7'h00;
                    end else if (bit_valid_in) begin
                        if (run_r == 7'(LOCK_RUN - 1)) begin
                            state_r <= BRS_LOCKED;
                            win_r   <= 7'h00;
                            errs_r  <= 4'h0;
                        end
                        run_r <= run_r + 7'h01;
                    end
                end
                BRS_LOCKED: begin
                    if (resync_in || too_many) begin
                        state_r        <= BRS_HUNT;
                        run_r          <= 7'h00;
                        hunt_start_out <= 1'b1;
                    end else if (bit_valid_in) begin
                        // Window restarts so old errors age out
                        if (win_r == 7'(UNLOCK_WIN - 1)) begin
                            win_r  <= 7'h00;
                            errs_r <= 4'h0;
                        end else begin
                            win_r  <= win_r + 7'h01;
                            errs_r <= errs_r + {3'h0, bad_bit};
                        end
                    end
                end
            endcase
        end
    end

    assign locked_out = (state_r == BRS_LOCKED);

    lock_after_run_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        state_r == BRS_HUNT && bit_valid_in && !bit_mismatch_in && !resync_in
        && run_r == 7'(LOCK_RUN - 1) |=> locked_out)
        else $error("lock not taken after clean run");
endmodule // brs_lock_tracker

// File: verilog/brs_status.sv
// Behaviour
// - Loss flag sets whenever lock drops back to hunting
// - Loss flag holds after relock until read
// - Bit error flag sets on mismatch while locked
// - Status read clears bit error flag
// - Bit counter wrap sets its overflow flag
// - Error counter wrap sets its overflow flag
// - Read clears overflow flags until next wrap
// - Overflow enable gates overflow interrupt onto output
// - Overflow enable: zero masks, one enables
`include "brs_defs.svh"

module brs_status
    import brs_pkg::*;
#(
    parameter int ADDR_W   = 12,
    parameter int SAME_RUN = `BRS_SAME_RUN
) (
    input  wire logic              clock_in,
    input  wire logic              rst_b_in,
    // Receive checker side
    input  wire logic              bit_valid_in,
    input  wire logic              bit_in,
    input  wire logic              bit_mismatch_in,
    input  wire logic              resync_in,
    input  wire logic              bit_count_wrap_in,
    input  wire logic              err_count_wrap_in,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output brs_resp_t              s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output brs_resp_t              s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    // Interrupt
    output logic                   irq_out
);
    localparam brs_resp_t RESP_OKAY   = 2'h0;
    localparam brs_resp_t RESP_SLVERR = 2'h2;

    // Word index of a byte address, or all ones when misaligned or when any address bit above bit 9 is set
    function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] addr);
        if (addr[1:0] != 2'h0 || addr[ADDR_W-1:10] != '0) begin
            return 8'hFF;
        end
        return addr[9:2];
    endfunction

    // Register storage
    logic [7:0]        ctrl_r;
    logic [2:0]        irq_mask_r;
    logic [2:0]        irq_stat_r;
    logic              ones_r;
    logic              zeros_r;
    logic              loss_r;
    logic              berr_r;
    logic              bco_r;
    logic              eco_r;
    logic              lock_d_r;
    logic              last_bit_r;
    logic [6:0]        same_r;

    // Bus handshake state
    logic              aw_hold_r;
    logic              w_hold_r;
    logic [7:0]        aw_idx_r;
    logic [7:0]        w_data_r;
    logic              w_lane0_r;

    // Checker wires
    logic              locked;
    logic              hunt_start;
    logic              lock_change;
    logic              berr_set;
    logic              ones_set;
    logic              zeros_set;
    logic              wr_fire;
    logic              rd_fire;
    logic              st_rd;
    logic [7:0]        rd_idx;
    logic [7:0]        status_val;
    logic [2:0]        irq_gate;
    logic              irq_nxt;

    brs_lock_tracker u_lock (
        .clock_in        (clock_in),
        .rst_b_in        (rst_b_in),
        .bit_valid_in    (bit_valid_in),
        .bit_mismatch_in (bit_mismatch_in),
        .resync_in       (resync_in),
        .locked_out      (locked),
        .hunt_start_out  (hunt_start)
    );

    // Event decode
    assign lock_change = locked != lock_d_r;
    assign berr_set    = bit_valid_in && bit_mismatch_in && locked;
    assign ones_set    = bit_valid_in && bit_in && last_bit_r
                         && same_r == 7'(SAME_RUN - 1);
    assign zeros_set   = bit_valid_in && !bit_in && !last_bit_r
                         && same_r == 7'(SAME_RUN - 1);
    assign wr_fire     = aw_hold_r && w_hold_r && !s_axi_bvalid_out;
    assign rd_fire     = s_axi_arvalid_in && s_axi_arready_out;
    assign rd_idx      = word_idx(s_axi_araddr_in);
    assign st_rd       = rd_fire && rd_idx == `BRS_IDX_STATUS;

    // Read view of the receive status register, top bit reads zero
    assign status_val  = {1'b0, ones_r, zeros_r, loss_r, berr_r, bco_r, eco_r, locked};

    // Same-level run length tracking
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            last_bit_r <= 1'b0;
            same_r     <= 7'h00;
        end else if (bit_valid_in) begin
            last_bit_r <= bit_in;
            // Saturate so a long run does not retrigger by wrapping
            if (bit_in != last_bit_r || same_r == 7'h00) begin
                same_r <= 7'h01;
            end else if (same_r != 7'(SAME_RUN)) begin
                same_r <= same_r + 7'h01;
            end
        end
    end

    // Latched flags; a set in the read cycle survives the clear
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            ones_r  <= 1'b0;
            zeros_r <= 1'b0;
            loss_r  <= 1'b0;
            berr_r  <= 1'b0;
            bco_r   <= 1'b0;
            eco_r   <= 1'b0;
        end else begin
            ones_r  <= ones_set || (ones_r && !st_rd);
            zeros_r <= zeros_set || (zeros_r && !st_rd);
            loss_r  <= hunt_start || (loss_r && !st_rd);
            berr_r  <= berr_set || (berr_r && !st_rd);
            bco_r   <= bit_count_wrap_in || (bco_r && !st_rd);
            eco_r   <= err_count_wrap_in || (eco_r && !st_rd);
        end
    end

    // Delayed lock for change detection
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            lock_d_r <= 1'b0;
        end else begin
            lock_d_r <= locked;
        end
    end

    // Write address channel, one write in flight
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            aw_hold_r         <= 1'b0;
            aw_idx_r          <= 8'h00;
            s_axi_awready_out <= 1'b0;
        end else if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_hold_r         <= 1'b1;
            aw_idx_r          <= word_idx(s_axi_awaddr_in);
            s_axi_awready_out <= 1'b0;
        end else if (wr_fire) begin
            aw_hold_r         <= 1'b0;
        end else begin
            s_axi_awready_out <= !aw_hold_r && !s_axi_bvalid_out;
        end
    end

    // Write data channel; only the low lane carries register bits
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            w_hold_r         <= 1'b0;
            w_data_r         <= 8'h00;
            w_lane0_r        <= 1'b0;
            s_axi_wready_out <= 1'b0;
        end else if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_hold_r         <= 1'b1;
            w_data_r         <= s_axi_wdata_in[7:0];
            w_lane0_r        <= s_axi_wstrb_in[0];
            s_axi_wready_out <= 1'b0;
        end else if (wr_fire) begin
            w_hold_r         <= 1'b0;
        end else begin
            s_axi_wready_out <= !w_hold_r && !s_axi_bvalid_out;
        end
    end

    // Write response
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_out <= 1'b1;
            unique case (aw_idx_r)
                `BRS_IDX_CTRL, `BRS_IDX_STATUS,
                `BRS_IDX_IRQ_STAT, `BRS_IDX_IRQ_MASK: s_axi_bresp_out <= RESP_OKAY;
                default:                              s_axi_bresp_out <= RESP_SLVERR;
            endcase
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // Control and mask registers; status register is read only
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            ctrl_r     <= `BRS_CTRL_RST;
            irq_mask_r <= `BRS_IRQ_MASK_RST;
        end else if (wr_fire && w_lane0_r) begin
            if (aw_idx_r == `BRS_IDX_CTRL) begin
                ctrl_r <= w_data_r;
            end
            if (aw_idx_r == `BRS_IDX_IRQ_MASK) begin
                irq_mask_r <= w_data_r[2:0];
            end
        end
    end

    // Sticky interrupt events, write one to clear, set wins
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            irq_stat_r <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if ((i == `BRS_IQ_LOCK && lock_change)
                    || (i == `BRS_IQ_BIT_OVF && bit_count_wrap_in)
                    || (i == `BRS_IQ_ERR_OVF && err_count_wrap_in)) begin
                    irq_stat_r[i] <= 1'b1;
                end else if (wr_fire && w_lane0_r && aw_idx_r == `BRS_IDX_IRQ_STAT
                             && w_data_r[i]) begin
                    irq_stat_r[i] <= 1'b0;
                end
            end
        end
    end

    // Enable bits gate each source, then the mask
    assign irq_gate = {ctrl_r[`BRS_CT_OVF_IE], ctrl_r[`BRS_CT_OVF_IE],
                       ctrl_r[`BRS_CT_LOCK_IE]};
    assign irq_nxt  = |(irq_stat_r & irq_mask_r & irq_gate);

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= irq_nxt;
        end
    end

    // Read channel; data is captured at the address handshake
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rresp_out   <= RESP_OKAY;
            unique case (rd_idx)
                `BRS_IDX_CTRL:     s_axi_rdata_out <= {24'h00_0000, ctrl_r};
                `BRS_IDX_STATUS:   s_axi_rdata_out <= {24'h00_0000, status_val};
                `BRS_IDX_IRQ_STAT: s_axi_rdata_out <= {29'h0000_0000, irq_stat_r};
                `BRS_IDX_IRQ_MASK: s_axi_rdata_out <= {29'h0000_0000, irq_mask_r};
                default: begin
                    s_axi_rdata_out <= 32'h0000_0000;
                    s_axi_rresp_out <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid_out) begin
            if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end else begin
            s_axi_arready_out <= 1'b1;
        end
    end

    // Steps that the checks are built from
    sequence hunt_begin_s;
        hunt_start;
    endsequence

    sequence status_read_s;
        st_rd;
    endsequence

    sequence err_locked_s;
        bit_valid_in && bit_mismatch_in && locked;
    endsequence

    loss_set_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        hunt_begin_s |=> loss_r)
        else $error("loss flag not set on hunt start");

    loss_hold_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        loss_r && !st_rd |=> loss_r)
        else $error("loss flag dropped without a read");

    berr_set_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        err_locked_s |=> berr_r)
        else $error("bit error flag not set");

    berr_clear_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        status_read_s ##0 !berr_set ##1 !berr_set |=> !berr_r)
        else $error("bit error flag not cleared by read");

    bco_set_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        bit_count_wrap_in |=> bco_r ##0 irq_stat_r[`BRS_IQ_BIT_OVF])
        else $error("bit counter overflow not latched");

    eco_set_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        err_count_wrap_in |=> eco_r ##0 irq_stat_r[`BRS_IQ_ERR_OVF])
        else $error("error counter overflow not latched");

    ovf_stay_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !bco_r && !bit_count_wrap_in |=> !bco_r)
        else $error("overflow flag set without a wrap");

    ovf_irq_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        bit_count_wrap_in && irq_mask_r[`BRS_IQ_BIT_OVF] && ctrl_r[`BRS_CT_OVF_IE]
        ##1 irq_mask_r[`BRS_IQ_BIT_OVF] && ctrl_r[`BRS_CT_OVF_IE] |=> irq_out)
        else $error("overflow interrupt not raised");

    ovf_mask_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !$past(ctrl_r[`BRS_CT_OVF_IE])
        && !($past(irq_stat_r[`BRS_IQ_LOCK]) && $past(irq_mask_r[`BRS_IQ_LOCK]))
        |-> !irq_out)
        else $error("interrupt raised while masked");

    ones_run_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        ones_set |=> ones_r ##0 !zeros_set)
        else $error("all ones flag not set");
endmodule // brs_status

// File: test/brs_host_model.sv
module brs_host_model
    import brs_pkg::*;
(
    input  wire logic      clock_in,
    output logic [11:0]    awaddr_out,
    output logic           awvalid_out,
    input  wire logic      awready_in,
    output logic [31:0]    wdata_out,
    output logic [3:0]     wstrb_out,
    output logic           wvalid_out,
    input  wire logic      wready_in,
    input  wire brs_resp_t bresp_in,
    input  wire logic      bvalid_in,
    output logic           bready_out,
    output logic [11:0]    araddr_out,
    output logic           arvalid_out,
    input  wire logic      arready_in,
    input  wire logic      rvalid_in,
    output logic           rready_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus from time zero
    initial begin
        {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out} = '0;
        {bready_out, araddr_out, arvalid_out, rready_out} = '0;
    end

    // One write; released payload is inverted so stale values never look valid
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output brs_resp_t r);
        logic aw_p;
        logic w_p;
        @(posedge clock_in);
        awaddr_out  <= a;
        wdata_out   <= d;
        wstrb_out   <= 4'h1;
        awvalid_out <= 1'h1;
        wvalid_out  <= 1'h1;
        bready_out  <= 1'h1;
        aw_p = 1'h1;
        w_p  = 1'h1;
        while (aw_p || w_p) begin
            @(posedge clock_in);
            if (aw_p && awready_in) begin
                awvalid_out <= 1'h0;
                awaddr_out  <= ~a;
                aw_p = 1'h0;
            end
            if (w_p && wready_in) begin
                wvalid_out <= 1'h0;
                wdata_out  <= ~d;
                w_p = 1'h0;
            end
        end
        do @(posedge clock_in); while (!bvalid_in);
        r = bresp_in;
        bready_out <= 1'h0;
    endtask

    // One read; data is judged by the bench monitor at the rready edge
    task automatic rd(input logic [11:0] a);
        @(posedge clock_in);
        araddr_out  <= a;
        arvalid_out <= 1'h1;
        rready_out  <= 1'h1;
        do @(posedge clock_in); while (!arready_in);
        arvalid_out <= 1'h0;
        araddr_out  <= ~a;
        do @(posedge clock_in); while (!rvalid_in);
        rready_out <= 1'h0;
    endtask
endmodule // brs_host_model

// File: test/brs_status_tb_top.sv
`include "brs_defs.svh"

module brs_status_tb_top
    import brs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [11:0] A_CT = {2'h0, `BRS_IDX_CTRL, 2'h0};
    localparam logic [11:0] A_ST = {2'h0, `BRS_IDX_STATUS, 2'h0};
    localparam logic [11:0] A_IS = {2'h0, `BRS_IDX_IRQ_STAT, 2'h0};
    localparam logic [11:0] A_IM = {2'h0, `BRS_IDX_IRQ_MASK, 2'h0};
    localparam logic [11:0] A_NO = 12'h200;
    localparam brs_resp_t   OK   = 2'h0;
    localparam brs_resp_t   ERR  = 2'h2;

    logic        clk;
    logic        rst_b;
    logic        bit_valid;
    logic        bit_v;
    logic        mm;
    logic [2:0]  pv;
    logic [11:0] awaddr;
    logic [11:0] araddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq;
    brs_resp_t   bresp;
    brs_resp_t   rresp;
    logic [33:0] exq[$];
    int          mismatches = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          seed = 32'hF556;
    logic [31:0] rnd;

    brs_status u_brs_status (
        .clock_in(clk), .rst_b_in(rst_b), .bit_valid_in(bit_valid), .bit_in(bit_v),
        .bit_mismatch_in(mm), .resync_in(pv[0]), .bit_count_wrap_in(pv[1]),
        .err_count_wrap_in(pv[2]), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .irq_out(irq));

    brs_host_model u_brs_host_model (
        .clock_in(clk), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
        .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid), .wready_in(wready),
        .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr),
        .arvalid_out(arvalid), .arready_in(arready), .rvalid_in(rvalid),
        .rready_out(rready));

    // Free-running 200 MHz clock
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string n, input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Gap lets flags settle before the read handshake clears them
    task automatic rdx(input logic [11:0] a, input logic [31:0] d, input brs_resp_t r);
        repeat (4) @(posedge clk);
        exq.push_back({r, d});
        u_brs_host_model.rd(a);
    endtask

    task automatic wrx(input logic [11:0] a, input logic [31:0] d, input brs_resp_t r);
        brs_resp_t got;
        u_brs_host_model.wr(a, d, got);
        chk("bresp", {32'h0, got}, {32'h0, r});
    endtask

    task automatic irqx(input logic e);
        repeat (4) @(posedge clk);
        chk("irq_out", {33'h0, irq}, {33'h0, e});
    endtask

    // Mode 0 matching, 1 mismatching, 2 ones, 3 zeros
    task automatic bits(input int n, input int mode);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            bit_valid <= 1'h1;
            bit_v     <= (mode >= 2) ? (mode == 2) : i[0];
            mm        <= (mode == 1);
        end
        @(posedge clk);
        bit_valid <= 1'h0;
        bit_v     <= ~bit_v;
        mm        <= 1'h0;
    endtask

    // Index 0 resync, 1 bit counter wrap, 2 error counter wrap
    task automatic pulse(input int k);
        @(posedge clk);
        pv <= 3'h1 << k;
        @(posedge clk);
        pv <= 3'h0;
    endtask

    task automatic tend(input string n);
        $display("test %s done", n);
    endtask

    // Result monitor; a read with no note pending never matches
    always @(posedge clk) begin
        if (rvalid === 1'h1 && rready === 1'h1)
            chk("read", {rresp, rdata}, exq.size() ? exq.pop_front() : 34'h3FFFFFFFF);
    end

    // Hang guard, far above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        {rst_b, bit_valid, bit_v, mm, pv} = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge clk);
        rdx(A_ST, 32'h00, OK);
        rdx(A_CT, 32'h00, OK);
        rdx(A_IM, 32'h00, OK);
        rdx(A_NO, 32'h00, ERR);
        rdx(A_ST + 12'h001, 32'h00, ERR);
        wrx(A_NO, 32'hFF, ERR);
        rnd = $random(seed) & 32'h5F;
        wrx(A_CT, rnd, OK);
        rdx(A_CT, rnd, OK);
        wrx(A_ST, 32'hFF, OK);
        tend("registers");
        bits(31, 0);
        rdx(A_ST, 32'h00, OK);
        bits(1, 0);
        rdx(A_ST, 32'h01, OK);
        bits(1, 1);
        rdx(A_ST, 32'h09, OK);
        rdx(A_ST, 32'h01, OK);
        tend("bit error");
        pulse(0);
        bits(1, 1);
        rdx(A_ST, 32'h10, OK);
        bits(32, 0);
        rdx(A_ST, 32'h01, OK);
        bits(5, 1);
        rdx(A_ST, 32'h09, OK);
        bits(1, 1);
        bits(32, 0);
        rdx(A_ST, 32'h19, OK);
        rdx(A_ST, 32'h01, OK);
        bits(6, 1);
        rdx(A_ST, 32'h18, OK);
        rdx(A_ST, 32'h00, OK);
        rdx(A_IS, 32'h01, OK);
        wrx(A_CT, 32'h80, OK);
        wrx(A_IM, 32'h01, OK);
        irqx(1'h1);
        wrx(A_IS, 32'h01, OK);
        irqx(1'h0);
        tend("sync");
        wrx(A_CT, 32'h20, OK);
        wrx(A_IM, 32'h06, OK);
        pulse(1);
        irqx(1'h1);
        rdx(A_ST, 32'h04, OK);
        rdx(A_ST, 32'h00, OK);
        rdx(A_IS, 32'h02, OK);
        wrx(A_IS, 32'h02, OK);
        irqx(1'h0);
        wrx(A_CT, 32'h00, OK);
        pulse(2);
        irqx(1'h0);
        rdx(A_ST, 32'h02, OK);
        rdx(A_ST, 32'h00, OK);
        wrx(A_CT, 32'h20, OK);
        irqx(1'h1);
        wrx(A_IS, 32'h04, OK);
        irqx(1'h0);
        tend("overflow");
        bits(32, 2);
        rdx(A_ST, 32'h41, OK);
        bits(31, 3);
        rdx(A_ST, 32'h01, OK);
        bits(1, 3);
        rdx(A_ST, 32'h21, OK);
        tend("runs");
        repeat (10) @(posedge clk);
        results();
    end
endmodule // brs_status_tb_top
